//--- core/host_link_pkg.sv
package host_link_pkg;

	// configuration space offsets
	localparam logic [7:0]  CFG_BAR_OFS        = 8'h10;
	localparam logic [7:0]  CFG_SUBSYS_OFS     = 8'h2c;
	localparam logic [7:0]  CFG_LINK_ENH_OFS   = 8'hd4;
	localparam logic [7:0]  CFG_ALIAS_OFS      = 8'hf8;

	// link enhancement control fields
	localparam int          LE_DV_TS_BIT       = 8;
	localparam int          LE_PRIO_BIT        = 7;
	localparam int          LE_RSVD2_BIT       = 2;
	localparam int          LE_ACCEL_BIT       = 1;
	localparam logic [31:0] LE_WRITE_MASK      = 32'h0000_0186;
	localparam logic [31:0] LE_RESET           = 32'h0000_0000;

	// subsystem alias fields and reset
	localparam int          ALIAS_DEV_LSB      = 16;
	localparam int          ALIAS_VEN_LSB      = 0;
	localparam logic [31:0] ALIAS_RESET        = 32'h0000_0000;

	// 2K-byte window decoded from the base address register
	localparam logic [31:0] BAR_ADDR_MASK      = 32'hffff_f800;
	localparam logic [31:0] BAR_RESET          = 32'h0000_0000;
	localparam logic [31:0] REG_RESET          = 32'h0000_0000;

	// memory-mapped offsets inside the window
	localparam logic [10:0] OFS_SPEC_REVISION  = 11'h000;
	localparam logic [10:0] OFS_UID_ROM        = 11'h004;
	localparam logic [10:0] OFS_TX_RETRY       = 11'h008;
	localparam logic [10:0] OFS_CSR_DATA       = 11'h00c;
	localparam logic [10:0] OFS_CSR_COMPARE    = 11'h010;
	localparam logic [10:0] OFS_CSR_CONTROL    = 11'h014;
	localparam logic [10:0] OFS_ROM_HEADER     = 11'h018;
	localparam logic [10:0] OFS_BUS_IDENT      = 11'h01c;
	localparam logic [10:0] OFS_BUS_OPTIONS    = 11'h020;
	localparam logic [10:0] OFS_UID_HIGH       = 11'h024;
	localparam logic [10:0] OFS_UID_LOW        = 11'h028;
	localparam logic [10:0] OFS_ROM_BASE       = 11'h034;
	localparam logic [10:0] OFS_POSTED_LOW     = 11'h038;
	localparam logic [10:0] OFS_POSTED_HIGH    = 11'h03c;
	localparam logic [10:0] OFS_MAKER_EXT      = 11'h040;
	localparam logic [10:0] OFS_HOST_CTL_SET   = 11'h050;
	localparam logic [10:0] OFS_HOST_CTL_CLR   = 11'h054;
	localparam logic [10:0] OFS_NODE_BUF       = 11'h064;
	localparam logic [10:0] OFS_NODE_COUNT     = 11'h068;
	localparam logic [10:0] OFS_ISO_HI_SET     = 11'h070;
	localparam logic [10:0] OFS_ISO_HI_CLR     = 11'h074;
	localparam logic [10:0] OFS_ISO_LO_SET     = 11'h078;
	localparam logic [10:0] OFS_ISO_LO_CLR     = 11'h07c;
	localparam logic [10:0] OFS_MAPPED_END     = 11'h080;

	// clear-address read masks of the paired registers
	localparam logic [31:0] HOST_CTL_CLR_MASK  = 32'hffff_ffff;
	localparam logic [31:0] ISO_CLR_MASK       = 32'hffff_ffff;

	// stream format that selects the timestamp enhancement
	localparam logic [5:0]  DV_CIP_FORMAT      = 6'h00;

	// one register access from the host side
	typedef struct packed {
		logic        write;
		logic        cfg_space;
		logic [31:0] addr;
		logic [31:0] wdata;
	} access_req_t;

	// how a word of the window behaves
	typedef enum logic [2:0] {
		KIND_RSVD, KIND_RO, KIND_RW, KIND_STICKY, KIND_SET, KIND_CLR
	} word_kind_t;

endpackage : host_link_pkg

//--- core/host_link_register_bank.sv
`timescale 1ns/100ps
module host_link_register_bank #(
	parameter logic [31:0] SPEC_REVISION_VALUE = 32'h0001_0010,
	parameter logic [31:0] BUS_IDENT_VALUE     = 32'h3133_3934,
	parameter logic [31:0] MAKER_EXT_VALUE     = 32'h0000_0000  // arbitrary value
) (
	// clock and synchronous reset
	input  wire logic                        mclk,
	input  wire logic                        reset,
	// reset pins
	input  wire logic                        pcie_reset_n,
	input  wire logic                        global_reset_n,
	output logic                             fundamental_reset_n,
	// register access port
	input  wire logic                        req_valid,
	input  wire host_link_pkg::access_req_t  req,
	output logic                             resp_valid,
	output logic [31:0]                      resp_rdata,
	// transmit stream and link controls
	input  wire logic [5:0]                  cip_format_code,
	output logic                             dv_ts_apply,
	output logic                             dv_timestamp_enhance_en,
	output logic                             priority_arb_en,
	output logic                             accel_support_en,
	// state shown to and taken from the link core
	input  wire logic [31:0]                 posted_addr_low,
	input  wire logic [31:0]                 posted_addr_high,
	output logic [31:0]                      host_ctl,
	output logic [63:0]                      iso_chan_mask,
	output logic [31:0]                      subsystem_id,
	output logic [31:0]                      window_base
);

	// pin synchronisers; they run through the ordinary reset as well, so a pin held
	// low while reset is up still reaches the sticky flops and the reset output
	// no reset of their own: the pins define them within two edges
	logic pcie_meta;
	logic pcie_sync;
	logic glob_meta;
	logic glob_sync;
	always_ff @(posedge mclk)
	begin
		pcie_meta <= pcie_reset_n;
		pcie_sync <= pcie_meta;
		glob_meta <= global_reset_n;
		glob_sync <= glob_meta;
	end

	// reset classes
	wire fund_now  = ~(pcie_sync & glob_sync);
	wire perst_now = ~pcie_sync | fund_now;
	wire soft_now  = reset | fund_now;

	// access decode
	wire        cfg_wr     = req_valid & req.write & req.cfg_space;
	wire        mem_access = req_valid & ~req.cfg_space;
	wire [7:0]  cfg_ofs    = {req.addr[7:2], 2'b00};
	wire        in_window  = (req.addr & host_link_pkg::BAR_ADDR_MASK) == window_base;
	wire [10:0] mem_ofs    = {req.addr[10:2], 2'b00};
	wire        mem_hit    = mem_access & in_window & (mem_ofs < host_link_pkg::OFS_MAPPED_END);
	wire [4:0]  mem_idx    = req.addr[6:2];

	// classify each word of the window
	function automatic host_link_pkg::word_kind_t word_kind(input logic [4:0] idx);
		logic [10:0] ofs;
		ofs = {4'h0, idx, 2'b00};
		case (ofs)
			host_link_pkg::OFS_SPEC_REVISION,
			host_link_pkg::OFS_BUS_IDENT,
			host_link_pkg::OFS_POSTED_LOW,
			host_link_pkg::OFS_POSTED_HIGH,
			host_link_pkg::OFS_MAKER_EXT:    word_kind = host_link_pkg::KIND_RO;
			host_link_pkg::OFS_UID_ROM,
			host_link_pkg::OFS_TX_RETRY,
			host_link_pkg::OFS_CSR_DATA,
			host_link_pkg::OFS_CSR_COMPARE,
			host_link_pkg::OFS_CSR_CONTROL,
			host_link_pkg::OFS_ROM_HEADER,
			host_link_pkg::OFS_ROM_BASE,
			host_link_pkg::OFS_NODE_BUF,
			host_link_pkg::OFS_NODE_COUNT:   word_kind = host_link_pkg::KIND_RW;
			host_link_pkg::OFS_BUS_OPTIONS,
			host_link_pkg::OFS_UID_HIGH,
			host_link_pkg::OFS_UID_LOW:      word_kind = host_link_pkg::KIND_STICKY;
			host_link_pkg::OFS_HOST_CTL_SET,
			host_link_pkg::OFS_ISO_HI_SET,
			host_link_pkg::OFS_ISO_LO_SET:   word_kind = host_link_pkg::KIND_SET;
			host_link_pkg::OFS_HOST_CTL_CLR,
			host_link_pkg::OFS_ISO_HI_CLR,
			host_link_pkg::OFS_ISO_LO_CLR:   word_kind = host_link_pkg::KIND_CLR;
			default:                         word_kind = host_link_pkg::KIND_RSVD;
		endcase
	endfunction : word_kind

	// words cleared by pcie reset rather than by the ordinary reset
	function automatic logic perst_class(input logic [4:0] idx);
		logic [10:0] ofs;
		ofs = {4'h0, idx, 2'b00};
		perst_class = (word_kind(idx) == host_link_pkg::KIND_STICKY)
			| (ofs == host_link_pkg::OFS_HOST_CTL_SET);
	endfunction : perst_class

	// mask applied when the clear address of a pair is read
	function automatic logic [31:0] clear_read_mask(input logic [4:0] idx);
		logic [10:0] ofs;
		ofs = {4'h0, idx, 2'b00};
		clear_read_mask = (ofs == host_link_pkg::OFS_HOST_CTL_CLR)
			? host_link_pkg::HOST_CTL_CLR_MASK : host_link_pkg::ISO_CLR_MASK;
	endfunction : clear_read_mask

	// window storage; a pair keeps its value at the set address word
	logic [31:0] win_regs [32];
	host_link_pkg::word_kind_t acc_kind;
	assign acc_kind = word_kind(mem_idx);
	wire       is_pair_clr = acc_kind == host_link_pkg::KIND_CLR;
	wire [4:0] store_idx   = is_pair_clr ? mem_idx - 5'd1 : mem_idx;
	wire [31:0] store_cur  = win_regs[store_idx];
	wire storable = (acc_kind != host_link_pkg::KIND_RO) & (acc_kind != host_link_pkg::KIND_RSVD);
	wire mem_wr   = mem_hit & req.write & storable;
	wire [31:0] next_word =
		(acc_kind == host_link_pkg::KIND_SET) ? (store_cur | req.wdata) :
		is_pair_clr                           ? (store_cur & ~req.wdata) :
		req.wdata;

	// update and reset of the window words
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < 32; i++)
		begin
			if (perst_class(5'(i)) ? perst_now : soft_now)
				win_regs[i] <= host_link_pkg::REG_RESET;
			else if (mem_wr && store_idx == 5'(i))
				win_regs[i] <= next_word;
		end
	end

	// configuration registers: base address is ordinary, alias and enhancement are sticky
	logic [31:0] link_enh;
	logic [31:0] alias_reg;
	wire bar_wr   = cfg_wr & (cfg_ofs == host_link_pkg::CFG_BAR_OFS);
	wire alias_wr = cfg_wr & (cfg_ofs == host_link_pkg::CFG_ALIAS_OFS);
	wire le_wr    = cfg_wr & (cfg_ofs == host_link_pkg::CFG_LINK_ENH_OFS);
	always_ff @(posedge mclk)
	begin
		if (soft_now)
			window_base <= host_link_pkg::BAR_RESET;
		else if (bar_wr)
			window_base <= req.wdata & host_link_pkg::BAR_ADDR_MASK;
	end

	// sticky registers ignore the ordinary reset on purpose
	always_ff @(posedge mclk)
	begin
		if (fund_now)
		begin
			alias_reg <= host_link_pkg::ALIAS_RESET;
			link_enh  <= host_link_pkg::LE_RESET;
		end
		else
		begin
			if (alias_wr)
				alias_reg <= req.wdata;
			if (le_wr)
				link_enh <= req.wdata & host_link_pkg::LE_WRITE_MASK;
		end
	end

	// the subsystem id registers are the alias flops themselves, so they never disagree
	assign subsystem_id = alias_reg;

	// reads of the window
	function automatic logic [31:0] window_read(input logic [4:0] idx,
		input logic [31:0] cur, input logic [31:0] pst_lo, input logic [31:0] pst_hi);
		logic [10:0] ofs;
		ofs = {4'h0, idx, 2'b00};
		case (word_kind(idx))
			host_link_pkg::KIND_RO:
				case (ofs)
					host_link_pkg::OFS_SPEC_REVISION: window_read = SPEC_REVISION_VALUE;
					host_link_pkg::OFS_BUS_IDENT:     window_read = BUS_IDENT_VALUE;
					host_link_pkg::OFS_POSTED_LOW:    window_read = pst_lo;
					host_link_pkg::OFS_POSTED_HIGH:   window_read = pst_hi;
					default:                          window_read = MAKER_EXT_VALUE;
				endcase
			host_link_pkg::KIND_RW,
			host_link_pkg::KIND_STICKY,
			host_link_pkg::KIND_SET:  window_read = cur;
			host_link_pkg::KIND_CLR:  window_read = cur & clear_read_mask(idx);
			default:                  window_read = '0;
		endcase
	endfunction : window_read

	// read selection for both spaces
	wire [31:0] mem_rdata = mem_hit ? window_read(mem_idx, store_cur, posted_addr_low,
		posted_addr_high) : 32'h0000_0000;
	wire [31:0] cfg_rdata =
		(cfg_ofs == host_link_pkg::CFG_BAR_OFS)      ? window_base :
		(cfg_ofs == host_link_pkg::CFG_SUBSYS_OFS)   ? subsystem_id :
		(cfg_ofs == host_link_pkg::CFG_ALIAS_OFS)    ? alias_reg :
		(cfg_ofs == host_link_pkg::CFG_LINK_ENH_OFS) ? link_enh :
		32'h0000_0000;
	wire [31:0] next_rdata = req.write ? 32'h0000_0000
		: (req.cfg_space ? cfg_rdata : mem_rdata);

	// answer every access one cycle later
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			resp_valid <= 1'b0;
			resp_rdata <= 32'h0000_0000;
		end
		else
		begin
			resp_valid <= req_valid;
			resp_rdata <= req_valid ? next_rdata : 32'h0000_0000;
		end
	end

	// link controls come from flops so the link core sees clean levels
	wire next_dv_apply = link_enh[host_link_pkg::LE_DV_TS_BIT]
		& (cip_format_code == host_link_pkg::DV_CIP_FORMAT);
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			dv_ts_apply <= 1'b0;
		end
		else
		begin
			dv_ts_apply <= next_dv_apply;
		end
	end

	// the reset output follows the pins even while reset is up, so it is never masked
	always_ff @(posedge mclk)
	begin
		fundamental_reset_n <= ~fund_now;
	end
	assign dv_timestamp_enhance_en = link_enh[host_link_pkg::LE_DV_TS_BIT];
	assign priority_arb_en         = link_enh[host_link_pkg::LE_PRIO_BIT];
	assign accel_support_en        = link_enh[host_link_pkg::LE_ACCEL_BIT];

	// bit 2 is stored as written; the core relies on software leaving it at zero
	// and it has no effect here beyond read back

	// stored pair values shown to the link core
	assign host_ctl      = win_regs[host_link_pkg::OFS_HOST_CTL_SET[6:2]];
	assign iso_chan_mask = {win_regs[host_link_pkg::OFS_ISO_HI_SET[6:2]],
		win_regs[host_link_pkg::OFS_ISO_LO_SET[6:2]]};

	// checks

	dv_apply_a: assert property (@(posedge mclk) disable iff (reset)
		!$past(reset) |-> dv_ts_apply == $past(link_enh[host_link_pkg::LE_DV_TS_BIT]
			&& cip_format_code == host_link_pkg::DV_CIP_FORMAT))
		else $error("dv timestamp apply does not follow enable and format");

	prio_write_a: assert property (@(posedge mclk) disable iff (reset)
		(le_wr && !fund_now) |=> (priority_arb_en == $past(req.wdata[host_link_pkg::LE_PRIO_BIT])))
		else $error("priority enable not taken from write");

	accel_write_a: assert property (@(posedge mclk) disable iff (reset)
		(le_wr && !fund_now) |=> (accel_support_en == $past(req.wdata[host_link_pkg::LE_ACCEL_BIT])))
		else $error("acceleration enable not taken from write");

	le_rsvd_zero_a: assert property (@(posedge mclk) disable iff (reset)
		(req_valid && !req.write && req.cfg_space && cfg_ofs == host_link_pkg::CFG_LINK_ENH_OFS)
		|=> (resp_rdata[9] == 1'b0 && resp_rdata[6:3] == 4'h0 && resp_rdata[0] == 1'b0))
		else $error("reserved enhancement bits read nonzero");

	alias_readback_a: assert property (@(posedge mclk) disable iff (reset)
		(alias_wr && !fund_now) ##1 (!alias_wr && !fund_now)
		##1 (req_valid && !req.write && req.cfg_space
			&& cfg_ofs == host_link_pkg::CFG_SUBSYS_OFS && !fund_now)
		|=> resp_rdata == $past(req.wdata, 3))
		else $error("subsystem id does not match alias write");

	sticky_hold_a: assert property (@(posedge mclk)
		(reset && !fund_now && !alias_wr) |=> $stable(alias_reg))
		else $error("alias changed on a non-fundamental reset");

	fund_follow_a: assert property (@(posedge mclk) disable iff (reset)
		(!pcie_reset_n || !global_reset_n) |-> ##3 !fundamental_reset_n)
		else $error("fundamental reset missed a reset pin");

	pair_set_a: assert property (@(posedge mclk) disable iff (reset)
		(mem_wr && acc_kind == host_link_pkg::KIND_SET && !perst_now && !soft_now)
		|=> ((win_regs[$past(store_idx)] & $past(req.wdata)) == $past(req.wdata)))
		else $error("set address failed to set bits");

	pair_clr_a: assert property (@(posedge mclk) disable iff (reset)
		(mem_wr && is_pair_clr)
		|=> ((win_regs[$past(store_idx)] & $past(req.wdata)) == 32'h0000_0000))
		else $error("clear address failed to clear bits");

	rsvd_read_a: assert property (@(posedge mclk) disable iff (reset)
		(mem_access && !req.write && acc_kind == host_link_pkg::KIND_RSVD)
		|=> (resp_valid && resp_rdata == 32'h0000_0000))
		else $error("reserved window offset read nonzero");

	perst_clear_a: assert property (@(posedge mclk) disable iff (reset)
		(!pcie_sync) |=> (host_ctl == 32'h0000_0000))
		else $error("host control survived pcie reset");

	// response timing, reset classes, decode limits, read paths of the pairs, alias fields and timestamp gating

	resp_pulse_a: assert property (@(posedge mclk) disable iff (reset)
		req_valid |=> resp_valid)
		else $error("access not answered one cycle later");

	write_rdata_a: assert property (@(posedge mclk) disable iff (reset)
		(req_valid && req.write)
		|=> (resp_rdata == 32'h0000_0000))
		else $error("write answered with nonzero data");

	fund_clear_a: assert property (@(posedge mclk)
		fund_now |=> (alias_reg == 32'h0000_0000 && link_enh == 32'h0000_0000))
		else $error("sticky registers survived fundamental reset");

	le_hold_a: assert property (@(posedge mclk)
		(reset && !fund_now && !le_wr) |=> $stable(link_enh))
		else $error("enhancement bits changed on a non-fundamental reset");

	host_keep_a: assert property (@(posedge mclk)
		(reset && !perst_now && !mem_wr)
		|=> $stable(host_ctl))
		else $error("host control changed on the ordinary reset");

	ord_clear_a: assert property (@(posedge mclk)
		reset |=> (iso_chan_mask == 64'h0000_0000_0000_0000
			&& window_base == 32'h0000_0000))
		else $error("ordinary registers survived the ordinary reset");

	bar_write_a: assert property (@(posedge mclk) disable iff (reset)
		(bar_wr && !soft_now) |=> (window_base[10:0] == 11'h000
			&& window_base[31:11] == $past(req.wdata[31:11])))
		else $error("base address not taken from write");

	window_out_a: assert property (@(posedge mclk) disable iff (reset)
		(mem_access && !req.write && !in_window)
		|=> (resp_rdata == 32'h0000_0000))
		else $error("read outside the window returned data");

	set_read_a: assert property (@(posedge mclk) disable iff (reset)
		(mem_hit && !req.write && acc_kind == host_link_pkg::KIND_SET)
		|=> (resp_rdata == $past(store_cur)))
		else $error("set address read differs from register");

	clr_read_a: assert property (@(posedge mclk) disable iff (reset)
		(mem_hit && !req.write && is_pair_clr)
		|=> ((resp_rdata & ~$past(store_cur)) == 32'h0000_0000))
		else $error("clear address read shows bits the register lacks");

	alias_fields_a: assert property (@(posedge mclk) disable iff (reset)
		(alias_wr && !fund_now) |=> (subsystem_id[31:16] == $past(req.wdata[31:16])
			&& subsystem_id[15:0] == $past(req.wdata[15:0])))
		else $error("subsystem id fields not taken from alias write");

	dv_off_a: assert property (@(posedge mclk) disable iff (reset)
		(cip_format_code != host_link_pkg::DV_CIP_FORMAT) |=> !dv_ts_apply)
		else $error("timestamp applied to a stream of another format");

endmodule : host_link_register_bank

//--- bench/host_model.sv
`timescale 1ns/100ps
module host_model (
	// clock
	input  wire logic                  mclk,
	// answer from the bank
	input  wire logic                  resp_valid,
	input  wire logic [31:0]           resp_rdata,
	// request to the bank
	output logic                       req_valid,
	output host_link_pkg::access_req_t req
);
	initial
	begin
		req_valid = 1'b0;
		req = '0;
	end

	// one access held over its taking edge; answer looked at once settled
	task access(input logic wr, input logic cfg, input logic [31:0] addr,
		input logic [31:0] wdata, output logic [31:0] rdata);
		int n;
		begin
			@(posedge mclk);
			req_valid <= 1'b1;
			req <= '{write: wr, cfg_space: cfg, addr: addr, wdata: wdata};
			@(posedge mclk);
			req_valid <= 1'b0;
			// an idle bus carries the inverse so stale values never look valid
			req <= ~req;
			#1;
			n = 0;
			while (resp_valid !== 1'b1 && n < 4)
			begin
				@(posedge mclk);
				#1;
				n++;
			end
			rdata = (resp_valid === 1'b1) ? resp_rdata : 32'hdead_beef;
		end
	endtask : access
endmodule : host_model

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic                       mclk, reset, pcie_reset_n, global_reset_n;
	logic                       req_valid, resp_valid, fundamental_reset_n;
	logic                       dv_ts_apply, dv_en, prio_en, accel_en;
	logic [5:0]                 cip_format_code;
	logic [31:0]                resp_rdata, host_ctl, subsystem_id, window_base, rd, base;
	logic [31:0]                posted_addr_low, posted_addr_high;
	logic [63:0]                iso_chan_mask;
	host_link_pkg::access_req_t req;
	int                         bad_count, checks_done;

	host_link_register_bank u_dut (.mclk(mclk), .reset(reset), .pcie_reset_n(pcie_reset_n),
		.global_reset_n(global_reset_n), .fundamental_reset_n(fundamental_reset_n),
		.req_valid(req_valid), .req(req), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.cip_format_code(cip_format_code), .dv_ts_apply(dv_ts_apply),
		.dv_timestamp_enhance_en(dv_en), .priority_arb_en(prio_en),
		.accel_support_en(accel_en), .posted_addr_low(posted_addr_low),
		.posted_addr_high(posted_addr_high), .host_ctl(host_ctl),
		.iso_chan_mask(iso_chan_mask), .subsystem_id(subsystem_id), .window_base(window_base));
	host_model u_host (.mclk(mclk), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.req_valid(req_valid), .req(req));

	// free-running 125 MHz clock
	initial mclk = 1'b0;
	always #4 mclk = ~mclk;

	task chk(input logic [95:0] got, input logic [95:0] exp);
		begin
			checks_done++;
			if (got !== exp)
			begin
				bad_count++;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask : chk

	// config and window accesses; window offsets ride on the current base
	task cw(input logic [7:0] o, input logic [31:0] d);
		u_host.access(1'b1, 1'b1, 32'(o), d, rd);
	endtask : cw
	task cr(input logic [7:0] o);
		u_host.access(1'b0, 1'b1, 32'(o), 32'h0000_0000, rd);
	endtask : cr
	task mw(input logic [31:0] o, input logic [31:0] d);
		u_host.access(1'b1, 1'b0, base + o, d, rd);
	endtask : mw
	task mr(input logic [31:0] o);
		u_host.access(1'b0, 1'b0, base + o, 32'h0000_0000, rd);
	endtask : mr

	task pins(input logic p, input logic g);
		@(posedge mclk);
		pcie_reset_n <= p;
		global_reset_n <= g;
		repeat (4) @(posedge mclk);
		#1;
	endtask : pins

	task t_reset_vals;
		cr(8'hd4);
		chk(rd, 32'h0000_0000);
		cr(8'hf8);
		chk(rd, 32'h0000_0000);
		chk(fundamental_reset_n, 1'h1);
	endtask : t_reset_vals

	task t_link_enh;
		cw(8'hd4, 32'hffff_fffb);
		cr(8'hd4);
		chk(rd, 32'h0000_0182);
		chk({dv_en, prio_en, accel_en}, 3'h7);
		@(posedge mclk);
		cip_format_code <= 6'h00;
		repeat (2) @(posedge mclk);
		#1;
		chk(dv_ts_apply, 1'h1);
		@(posedge mclk);
		cip_format_code <= 6'h20;
		repeat (2) @(posedge mclk);
		#1;
		chk(dv_ts_apply, 1'h0);
		cw(8'hd4, 32'h0000_0000);
		@(posedge mclk);
		cip_format_code <= 6'h00;
		repeat (2) @(posedge mclk);
		#1;
		chk({dv_ts_apply, dv_en, prio_en, accel_en}, 4'h0);
	endtask : t_link_enh

	task t_alias;
		cw(8'hf8, 32'habcd_1234);
		cr(8'h2c);
		chk(rd, 32'habcd_1234);
		cr(8'hf8);
		chk(rd, 32'habcd_1234);
		chk(subsystem_id, 32'habcd_1234);
	endtask : t_alias

	task t_window;
		logic [31:0] rsvd [5];
		begin
			rsvd = '{32'h0000_002c, 32'h0000_0044, 32'h0000_0060, 32'h0000_006c, 32'h0000_0080};
			cw(8'h10, 32'h1234_5fff);
			cr(8'h10);
			chk(rd, 32'h1234_5800);
			chk(window_base, 32'h1234_5800);
			base = 32'h1234_5800;
			mw(32'h0000_0018, 32'h5a5a_a5a5);
			mr(32'h0000_0018);
			chk(rd, 32'h5a5a_a5a5);
			mw(32'h0000_0818, 32'h0000_0000);
			mw(32'hffff_f818, 32'h0000_0000);
			mr(32'h0000_0018);
			chk(rd, 32'h5a5a_a5a5);
			mr(32'h0000_0818);
			chk(rd, 32'h0000_0000);
			foreach (rsvd[i])
			begin
				mw(rsvd[i], 32'hffff_ffff);
				mr(rsvd[i]);
				chk(rd, 32'h0000_0000);
			end
			mr(32'h0000_0038);
			chk(rd, posted_addr_low);
			mr(32'h0000_003c);
			chk(rd, posted_addr_high);
			mw(32'h0000_0000, 32'hffff_ffff);
			mr(32'h0000_0000);
			chk(rd, 32'h0001_0010);
			mr(32'h0000_001c);
			chk(rd, 32'h3133_3934);
		end
	endtask : t_window

	task t_pairs;
		logic [31:0] s [3];
		begin
			s = '{32'h0000_0050, 32'h0000_0070, 32'h0000_0078};
			foreach (s[i])
			begin
				mw(s[i], 32'h0000_f0f0);
				mw(s[i], 32'h0f00_0000);
				mw(s[i] + 32'h0000_0004, 32'h0000_3030);
				mr(s[i]);
				chk(rd, 32'h0f00_c0c0);
				mr(s[i] + 32'h0000_0004);
				chk(rd, 32'h0f00_c0c0);
			end
			chk({host_ctl, iso_chan_mask}, {3{32'h0f00_c0c0}});
		end
	endtask : t_pairs

	task t_resets;
		cw(8'hd4, 32'h0000_0182);
		@(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		base = 32'h0000_0000;
		cr(8'hf8);
		chk(rd, 32'habcd_1234);
		cr(8'hd4);
		chk(rd, 32'h0000_0182);
		cr(8'h10);
		chk(rd, 32'h0000_0000);
		mr(32'h0000_0018);
		chk(rd, 32'h0000_0000);
		mr(32'h0000_0050);
		chk(rd, 32'h0f00_c0c0);
		mr(32'h0000_0070);
		chk(rd, 32'h0000_0000);
		pins(1'b0, 1'b1);
		chk(fundamental_reset_n, 1'h0);
		pins(1'b1, 1'b1);
		cr(8'hf8);
		chk(rd, 32'h0000_0000);
		cr(8'hd4);
		chk(rd, 32'h0000_0000);
		mr(32'h0000_0050);
		chk(rd, 32'h0000_0000);
		pins(1'b1, 1'b0);
		chk(fundamental_reset_n, 1'h0);
		pins(1'b1, 1'b1);
		chk(fundamental_reset_n, 1'h1);
	endtask : t_resets

	task end_sim;
		begin
			$display("mismatches %0d comparisons %0d", bad_count, checks_done);
			if (bad_count == 0 && checks_done > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask : end_sim

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		bad_count++;
		end_sim();
	end

	initial
	begin
		bad_count = 0;
		checks_done = 0;
		base = 32'h0000_0000;
		reset = 1'b1;
		pcie_reset_n = 1'b0;
		global_reset_n = 1'b0;
		cip_format_code = 6'h20;
		posted_addr_low = 32'h1357_9bdf;
		posted_addr_high = 32'h2468_ace0;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		pcie_reset_n <= 1'b1;
		global_reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset_vals();
		t_link_enh();
		t_alias();
		t_window();
		t_pairs();
		t_resets();
		end_sim();
	end
endmodule : testbench
